/* File: io_map_defines.vh */
// constants for the channel mapping and output supervision block
// Overview of operation
// - four fixed bit orders, chosen by mapping mode, place 16 channels on image
// - mode 5 puts each channel on the bit given by its own assignment
// - duplicate free assignments are illegal; in mode 5 the block raises a mapping fault
// - in modes 1 to 4 the per-channel assignments are ignored
// - one mapping serves both input image and output image
// - mode 1: first byte ports 8..5, second byte ports 4..1, B above A
// - mode 2: first byte ports 4..1, second byte ports 8..5, B above A
// - mode 3: B channels first byte, A second; mode 4 swaps the bytes
// - default free assignment: ports 1-4 on first byte, 5-8 on second
// - rising control edge starts per-channel surveillance delay, then monitoring
// - surveillance delay 0 to 255 ms per channel, default 80 ms
// - static output fault must persist 5 ms before diagnostic rises
// - on lost communication each output takes its failsafe state
// - failsafe choice: force 0, force 1 or hold last; 0 is default
// - overload trips output; auto mode retries later, else wait control low
`ifndef IO_MAP_DEFINES_VH
`define IO_MAP_DEFINES_VH

`define NUM_CH 16
`define MODE_W 3
`define MODE_1 3'h1
`define MODE_2 3'h2
`define MODE_3 3'h3
`define MODE_4 3'h4
`define MODE_5 3'h5
`define ASSIGN_W 4
`define BYTE_HALF 4'h8

`define FS_LOW 2'h0
`define FS_HIGH 2'h1
`define FS_HOLD 2'h2

`define SURV_DEFAULT_MS 8'h50
`define SURV_DEFAULT_ALL {16{8'h50}}
`define FREE_DEFAULT_ALL 64'hfedcba9876543210
`define FILTER_MS 3'h5
`define RESTART_MS 7'h64

`define CLK_PERIOD_NS 8
`define MS_NS 1000000

`endif

/* File: out_supervisor.v */
// one output channel: surveillance delay, fault filter and restart
`include "io_map_defines.vh"
module out_supervisor (
    // clock and reset
    input wire i_ref_clk,
    input wire i_sys_rst,
    // timing and settings
    input wire i_tick_ms,
    input wire [7:0] i_surv_ms,
    input wire i_restart_auto,
    // command and sensed fault
    input wire i_ctrl,
    input wire i_fault,
    // results
    output reg o_drive,
    output reg o_diag
);
    reg ctrl_d_r;
    reg [7:0] surv_r;
    reg waiting_r;
    reg [2:0] filt_r;
    reg tripped_r;
    reg [6:0] retry_r;
    wire rise = i_ctrl & ~ctrl_d_r;
    wire fall = ~i_ctrl & ctrl_d_r;
    wire monitored = ~waiting_r & ~tripped_r;
    wire filt_done = (filt_r == `FILTER_MS);

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ctrl_d_r <= 1'b0;
            surv_r <= 8'h00;
            waiting_r <= 1'b0;
            filt_r <= 3'h0;
            tripped_r <= 1'b0;
            retry_r <= 7'h00;
            o_drive <= 1'b0;
            o_diag <= 1'b0;
        end else begin
            ctrl_d_r <= i_ctrl;
            if (rise) begin
                // a zero delay monitors at once
                surv_r <= i_surv_ms;
                waiting_r <= (i_surv_ms != 8'h00);
            end else if (fall) begin
                waiting_r <= 1'b0;
                surv_r <= 8'h00;
            end else if (waiting_r && i_tick_ms) begin
                surv_r <= surv_r - 8'h01;
                if (surv_r == 8'h01)
                    waiting_r <= 1'b0;
            end
            // fault must hold for whole ms ticks while monitored
            if (!monitored || !i_fault || rise || fall)
                filt_r <= 3'h0;
            else if (i_tick_ms && !filt_done)
                filt_r <= filt_r + 3'h1;
            if (tripped_r) begin
                if (!i_ctrl) begin
                    tripped_r <= 1'b0;
                end else if (i_restart_auto && i_tick_ms) begin
                    retry_r <= retry_r - 7'h01;
                    if (retry_r == 7'h01) begin
                        // retry restarts the delay so inrush is not flagged
                        tripped_r <= 1'b0;
                        surv_r <= i_surv_ms;
                        waiting_r <= (i_surv_ms != 8'h00);
                    end
                end
            end else if (filt_done && i_ctrl) begin
                tripped_r <= 1'b1;
                retry_r <= `RESTART_MS;
            end
            o_drive <= i_ctrl & ~tripped_r & ~(filt_done & i_ctrl);
            o_diag <= filt_done | tripped_r;
        end
    end
endmodule // out_supervisor

/* File: io_bit_mapping.v */
// channel to process-image mapping, failsafe and output supervision
`include "io_map_defines.vh"
module io_bit_mapping #(
    parameter MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_sys_rst,
    // mapping configuration
    input wire [2:0] i_map_mode,
    input wire [63:0] i_free_assign,
    // output configuration
    input wire [127:0] i_surv_ms,
    input wire [31:0] i_failsafe_cfg,
    input wire [15:0] i_restart_auto,
    // cyclic exchange with the controller
    input wire i_comm_ok,
    input wire [15:0] i_out_image,
    output reg [15:0] o_in_image,
    // field side
    input wire [15:0] i_in_pins,
    input wire [15:0] i_fault_pins,
    output wire [15:0] o_out_pins,
    // status
    output wire [15:0] o_diag,
    output reg o_map_fault
);
    // image bit that carries channel c (c = 2*(port-1) + B)
    function [3:0] pos_of;
        input [2:0] mode;
        input [3:0] c;
        input [3:0] fa;
        begin
            case (mode)
                `MODE_1: pos_of = c ^ `BYTE_HALF;
                `MODE_2: pos_of = c;
                `MODE_3: pos_of = {~c[0], c[3:1]};
                `MODE_4: pos_of = {c[0], c[3:1]};
                `MODE_5: pos_of = fa;
                default: pos_of = c;
            endcase
        end
    endfunction

    reg [15:0] in_s1_r, in_s2_r, in_s3_r, in_stable_r;
    reg [15:0] flt_s1_r, flt_s2_r, flt_s3_r, flt_stable_r;
    reg [31:0] ms_cnt_r;
    reg tick_ms_r;
    reg [15:0] ctrl_r, ctrl_nxt;
    reg [15:0] hold_r;
    reg [15:0] img_nxt;
    reg [15:0] mapped_out;
    reg dup_nxt;
    integer c, j, k;

    // pins settle through three stages; take a value once the last two stages agree
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            in_s1_r <= 16'h0000;
            in_s2_r <= 16'h0000;
            in_s3_r <= 16'h0000;
            in_stable_r <= 16'h0000;
            flt_s1_r <= 16'h0000;
            flt_s2_r <= 16'h0000;
            flt_s3_r <= 16'h0000;
            flt_stable_r <= 16'h0000;
        end else begin
            in_s1_r <= i_in_pins;
            in_s2_r <= in_s1_r;
            in_s3_r <= in_s2_r;
            in_stable_r <= (in_s2_r & ~(in_s2_r ^ in_s3_r))
                | (in_stable_r & (in_s2_r ^ in_s3_r));
            flt_s1_r <= i_fault_pins;
            flt_s2_r <= flt_s1_r;
            flt_s3_r <= flt_s2_r;
            flt_stable_r <= (flt_s2_r & ~(flt_s2_r ^ flt_s3_r))
                | (flt_stable_r & (flt_s2_r ^ flt_s3_r));
        end
    end

    // shared millisecond tick
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ms_cnt_r <= 32'h0000_0000;
            tick_ms_r <= 1'b0;
        end else if (ms_cnt_r == MS_CYCLES - 1) begin
            ms_cnt_r <= 32'h0000_0000;
            tick_ms_r <= 1'b1;
        end else begin
            ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
            tick_ms_r <= 1'b0;
        end
    end

    // same position table for both directions
    always @* begin
        img_nxt = 16'h0000;
        mapped_out = 16'h0000;
        dup_nxt = 1'b0;
        for (c = 0; c < `NUM_CH; c = c + 1) begin
            // free fields only read in mode 5
            img_nxt[pos_of(i_map_mode, c[3:0],
                i_free_assign[c*4 +: 4])] = in_stable_r[c];
            mapped_out[c] = i_out_image[pos_of(i_map_mode, c[3:0],
                i_free_assign[c*4 +: 4])];
            for (j = c + 1; j < `NUM_CH; j = j + 1) begin
                if (i_free_assign[c*4 +: 4] == i_free_assign[j*4 +: 4])
                    dup_nxt = 1'b1;
            end
        end
        if (i_map_mode != `MODE_5)
            dup_nxt = 1'b0;
        if (i_map_mode < `MODE_1 || i_map_mode > `MODE_5)
            dup_nxt = 1'b1;
    end

    // failsafe selection per channel
    always @* begin
        ctrl_nxt = 16'h0000;
        // own index: a shared one would let both processes retrigger
        for (k = 0; k < `NUM_CH; k = k + 1) begin
            if (i_comm_ok)
                ctrl_nxt[k] = mapped_out[k];
            else begin
                case (i_failsafe_cfg[k*2 +: 2])
                    `FS_HIGH: ctrl_nxt[k] = 1'b1;
                    `FS_HOLD: ctrl_nxt[k] = hold_r[k];
                    default: ctrl_nxt[k] = 1'b0;
                endcase
            end
        end
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_in_image <= 16'h0000;
            o_map_fault <= 1'b0;
            ctrl_r <= 16'h0000;
            hold_r <= 16'h0000;
        end else begin
            o_in_image <= img_nxt;
            o_map_fault <= dup_nxt;
            ctrl_r <= ctrl_nxt;
            // hold tracks the last command seen while the link was up
            if (i_comm_ok)
                hold_r <= mapped_out;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g = g + 1) begin : ch
            out_supervisor u_sup (
                .i_ref_clk(i_ref_clk),
                .i_sys_rst(i_sys_rst),
                .i_tick_ms(tick_ms_r),
                .i_surv_ms(i_surv_ms[g*8 +: 8]),
                .i_restart_auto(i_restart_auto[g]),
                .i_ctrl(ctrl_r[g]),
                .i_fault(flt_stable_r[g]),
                .o_drive(o_out_pins[g]),
                .o_diag(o_diag[g])
            );
        end
    endgenerate
endmodule // io_bit_mapping

/* File: io_bit_mapping_sva.sv */
// port checker for the mapping and supervision block
module io_bit_mapping_sva #(
    parameter MS_CYCLES = 10
) (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire [2:0] i_map_mode,
    input wire [31:0] i_failsafe_cfg,
    input wire i_comm_ok,
    input wire [15:0] i_out_image,
    input wire [15:0] i_fault_pins,
    input wire [15:0] o_out_pins,
    input wire [15:0] o_diag,
    input wire o_map_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_reset_clear: assert property (disable iff (1'b0)
        i_sys_rst |=> o_out_pins == 16'h0 && o_diag == 16'h0 && !o_map_fault)
        else $error("outputs not cleared by reset");
    a_fixed_mode: assert property (
        i_map_mode >= 3'h1 && i_map_mode <= 3'h4 |=> !o_map_fault)
        else $error("map fault in a fixed mode");
    a_bad_mode: assert property (
        i_map_mode == 3'h0 || i_map_mode > 3'h5 |=> o_map_fault)
        else $error("invalid mode not flagged");
    a_fs_low: assert property (
        (!i_comm_ok && i_failsafe_cfg == 32'h0) [*2] |=> o_out_pins == 16'h0)
        else $error("failsafe low not applied");
    a_fs_high: assert property (
        (!i_comm_ok && i_failsafe_cfg == 32'h55555555 && o_diag == 16'h0) [*2]
        |=> o_out_pins == 16'hffff || o_diag != 16'h0)
        else $error("failsafe high not applied");
    // a tripped channel always shows in o_diag, hence the escape
    a_mode2_pass: assert property (
        (i_comm_ok && i_map_mode == 3'h2 && $stable(i_out_image)) [*3]
        |-> o_out_pins == i_out_image || o_diag != 16'h0)
        else $error("mode 2 output order wrong");
    a_mode1_pass: assert property (
        (i_comm_ok && i_map_mode == 3'h1 && $stable(i_out_image)) [*3]
        |-> o_out_pins == {i_out_image[7:0], i_out_image[15:8]}
        || o_diag != 16'h0)
        else $error("mode 1 output order wrong");
    // depths assume MS_CYCLES of 10
    a_diag_cause: assert property (
        $rose(o_diag[0]) |-> $past(i_fault_pins[0], 6)
        && $past(i_fault_pins[0], 30))
        else $error("diagnostic without filtered fault");
    cover property ($rose(o_map_fault));
    cover property ($rose(o_diag[0]));
    cover property (!i_comm_ok && o_out_pins != 16'h0);
endmodule // io_bit_mapping_sva

/* File: plc_model.sv */
// controller side of the cyclic exchange
module plc_model (
    input wire i_ref_clk,
    output logic o_comm_ok,
    output logic [15:0] o_out_image
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_comm_ok = 1'b0;
        o_out_image = 16'h0;
    end
    // with the link down the image is junk, so show the inverse
    task automatic send(input logic [15:0] img, input logic ok);
        @(negedge i_ref_clk);
        o_out_image <= ok ? img : ~o_out_image;
        o_comm_ok <= ok;
    endtask
endmodule // plc_model

/* File: io_bit_mapping_bench.sv */
// self-checking bench for the mapping and supervision block
module io_bit_mapping_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [2:0] i_map_mode = 3'h2;
    logic [63:0] i_free_assign = 64'h0123456789abcdef;
    logic [127:0] i_surv_ms = {16{8'h50}};
    logic [31:0] i_failsafe_cfg = 32'h0;
    logic [15:0] i_restart_auto = 16'h0;
    logic [15:0] i_in_pins = 16'h0;
    logic [15:0] i_fault_pins = 16'h0;
    logic i_comm_ok, o_map_fault;
    logic [15:0] i_out_image, o_in_image, o_out_pins, o_diag;
    logic [15:0] exp_in, exp_out;
    int num_errors = 0;
    int checks_done = 0;
    int m, c;
    always #4 i_ref_clk = ~i_ref_clk;
    io_bit_mapping #(.MS_CYCLES(10)) u_dut (.i_ref_clk, .i_sys_rst,
        .i_map_mode, .i_free_assign, .i_surv_ms, .i_failsafe_cfg,
        .i_restart_auto, .i_comm_ok, .i_out_image, .o_in_image,
        .i_in_pins, .i_fault_pins, .o_out_pins, .o_diag, .o_map_fault);
    plc_model u_plc (.i_ref_clk, .o_comm_ok(i_comm_ok),
        .o_out_image(i_out_image));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // image bit of a channel, built from port number and channel letter
    function automatic logic [3:0] pos(input logic [2:0] md, input int ch);
        int p, b;
        p = ch / 2;
        b = ch % 2;
        case (md)
            3'h1: pos = 4'((p < 4 ? 8 : 0) + 2 * (p % 4) + b);
            3'h2: pos = 4'((p < 4 ? 0 : 8) + 2 * (p % 4) + b);
            3'h3: pos = 4'((b == 1 ? 0 : 8) + p);
            3'h4: pos = 4'((b == 1 ? 8 : 0) + p);
            3'h5: pos = i_free_assign[4 * ch +: 4];
            default: pos = 4'(ch);
        endcase
    endfunction
    initial begin
        wait_cyc(12);
        i_sys_rst = 1'b0;
        wait_cyc(4);
        // reversed free table stays set, so modes 1 to 4 must ignore it
        for (m = 1; m <= 5; m++) begin
            i_map_mode = m[2:0];
            i_in_pins = 16'h8c31;
            u_plc.send(16'h3c96, 1'b1);
            wait_cyc(8);
            for (c = 0; c < 16; c++) begin
                exp_in[pos(i_map_mode, c)] = i_in_pins[c];
                exp_out[c] = i_out_image[pos(i_map_mode, c)];
            end
            check(o_out_pins, exp_out);
            check(o_in_image, exp_in);
            check(16'(o_map_fault), 16'h0);
        end
        i_free_assign = 64'h0123456789abcdee;
        wait_cyc(3);
        check(16'(o_map_fault), 16'h1);
        i_free_assign = 64'hfedcba9876543210;
        wait_cyc(8);
        check(16'(o_map_fault), 16'h0);
        check(o_in_image, 16'h8c31);
        i_map_mode = 3'h0;
        wait_cyc(3);
        check(16'(o_map_fault), 16'h1);
        i_map_mode = 3'h2;
        u_plc.send(16'hff0f, 1'b1);
        wait_cyc(4);
        i_failsafe_cfg = 32'hffaa5500;
        u_plc.send(16'h0, 1'b0);
        wait_cyc(4);
        check(o_out_pins, 16'h0ff0);
        i_failsafe_cfg = 32'h55555555;
        wait_cyc(4);
        check(o_out_pins, 16'hffff);
        i_failsafe_cfg = 32'h0;
        wait_cyc(4);
        check(o_out_pins, 16'h0);
        i_surv_ms = {16{8'h0a}};
        u_plc.send(16'h0001, 1'b1);
        wait_cyc(4);
        i_fault_pins = 16'h0001;
        wait_cyc(80);
        check(o_diag, 16'h0);
        wait_cyc(120);
        check(o_diag, 16'h0001);
        check(o_out_pins, 16'h0);
        i_fault_pins = 16'h0;
        u_plc.send(16'h0, 1'b1);
        wait_cyc(6);
        u_plc.send(16'h0001, 1'b1);
        wait_cyc(6);
        check(o_out_pins, 16'h0001);
        check(o_diag, 16'h0);
        // fault stays; a one-cycle low restarts the delay from zero
        i_fault_pins = 16'h0001;
        wait_cyc(50);
        u_plc.send(16'h0, 1'b1);
        u_plc.send(16'h0001, 1'b1);
        wait_cyc(118);
        check(o_diag, 16'h0);
        wait_cyc(60);
        check(o_diag, 16'h0001);
        check(o_out_pins, 16'h0);
        // automatic restart retries after the restart interval
        i_restart_auto = 16'h0001;
        i_fault_pins = 16'h0;
        wait_cyc(900);
        check(o_out_pins, 16'h0);
        check(o_diag, 16'h0001);
        wait_cyc(110);
        check(o_out_pins, 16'h0001);
        check(o_diag, 16'h0);
        test_done();
    end
    // whole sequence is some 1560 cycles; this is far beyond it
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
endmodule // io_bit_mapping_bench
bind io_bit_mapping io_bit_mapping_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (
    .i_ref_clk, .i_sys_rst, .i_map_mode, .i_failsafe_cfg, .i_comm_ok,
    .i_out_image, .i_fault_pins, .o_out_pins, .o_diag, .o_map_fault);
